// >>> src/adcsr_pkg.sv
// Package for the converter channel-select and result readout block.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register bus.
package adcsr_pkg;

	// Register byte addresses: printed indices times four
	localparam logic [2:0]  IDX_RESULT      = 3'h3;
	localparam logic [2:0]  IDX_IDENT       = 3'h4;
	localparam logic [7:0]  ADDR_RESULT     = {3'h0, IDX_RESULT, 2'h0};
	localparam logic [7:0]  ADDR_IDENT      = {3'h0, IDX_IDENT, 2'h0};
	localparam logic [7:0]  ADDR_CONFIG     = 8'h20;
	localparam logic [7:0]  ADDR_STATUS     = 8'h24;
	localparam logic [7:0]  ADDR_IRQ_STAT   = 8'h28;
	localparam logic [7:0]  ADDR_IRQ_MASK   = 8'h2c;
	localparam logic [7:0]  ADDR_RESULT_ST  = 8'h30;

	// Config register fields
	localparam int          CFG_CHSEL_LSB   = 0;
	localparam int          CFG_COMMON_BIT  = 8;
	localparam int          CFG_APPEND_BIT  = 9;

	// Status register fields
	localparam int          STA_NOT_READY   = 7;

	// Interrupt bits
	localparam int          IRQ_RESULT_NEW  = 0;
	localparam int          IRQ_RESULT_READ = 1;
	localparam int          IRQ_WIDTH       = 2;

	// Reset values
	localparam logic [23:0] RESULT_RESET    = 24'h000000;
	localparam logic [7:0]  CHSEL_RESET     = 8'h00;
	localparam logic [3:0]  IDENT_LOW_NIB   = 4'h3;
	// Upper nibble of identification is arbitrary
	localparam logic [3:0]  IDENT_HIGH_DEF  = 4'h0;

	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

	// Decoded input routing
	typedef struct packed {
		logic [15:0] pos_sel;
		logic [15:0] neg_sel;
		logic        neg_common;
		logic [3:0]  channel;
	} adcsr_route_t;

	// One finished conversion from the modulator
	typedef struct packed {
		logic [23:0] data;
		logic [3:0]  channel;
	} adcsr_sample_t;

endpackage : adcsr_pkg

// >>> src/adcsr_route.sv
// Channel-select decoder: maps the channel-select field to input routing.
// Assumes the field and mode bit come from registers on the same clock.
`timescale 1ns/100ps
`default_nettype none
module adcsr_route
	import adcsr_pkg::*;
(
	// Selection
	input  wire logic [7:0] channel_select_field,
	input  wire logic       common_mode,
	// Routing
	output var adcsr_route_t route
);

	always_comb begin
		route = '0;
		route.pos_sel[channel_select_field[7:4]] = 1'b1;
		route.channel = channel_select_field[7:4];
		if (common_mode) begin
			route.neg_common = 1'b1;
		end else begin
			route.neg_sel[channel_select_field[3:0]] = 1'b1;
		end
	end

endmodule : adcsr_route
`default_nettype wire

// >>> src/adcsr_top.sv
// Channel selection, result register and identification of a converter.
// Assumes conversions arrive as one-cycle pulses on aclk from the modulator.
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module adcsr_top
	import adcsr_pkg::*;
#(
	parameter logic [3:0] IDENT_HIGH = IDENT_HIGH_DEF
)(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Modulator side
	input  wire logic        conv_done,
	input  wire logic [23:0] conv_data,
	// Analog routing and pins
	output var adcsr_route_t route,
	output logic             not_ready_n,
	output logic             irq
);

	// Registers
	logic [7:0]           chsel;
	logic                 common_mode;
	logic                 append_status;
	adcsr_sample_t        result;
	logic                 not_ready;
	logic [IRQ_WIDTH-1:0] irq_stat;
	logic [IRQ_WIDTH-1:0] irq_mask;
	logic [7:0]           next_chsel;
	logic                 next_common_mode;
	logic                 next_append_status;
	adcsr_sample_t        next_result;
	logic                 next_not_ready;
	logic [IRQ_WIDTH-1:0] next_irq_stat;
	logic [IRQ_WIDTH-1:0] next_irq_mask;

	// Bus state
	logic                 aw_held;
	logic                 w_held;
	logic [7:0]           aw_addr;
	logic [31:0]          w_data;
	logic [3:0]           w_strb;
	logic                 next_aw_held;
	logic                 next_w_held;
	logic [7:0]           next_aw_addr;
	logic [31:0]          next_w_data;
	logic [3:0]           next_w_strb;
	logic                 next_bvalid;
	logic [1:0]           next_bresp;
	logic                 next_rvalid;
	logic [31:0]          next_rdata;
	logic [1:0]           next_rresp;

	logic                 wr_fire;
	logic                 rd_fire;
	logic [7:0]           status_byte;
	logic [7:0]           ident_byte;
	logic [IRQ_WIDTH-1:0] irq_events;

	adcsr_route u_route (
		.channel_select_field (chsel),
		.common_mode          (common_mode),
		.route                (route)
	);

	assign status_byte = {not_ready, 3'h0, result.channel};
	assign ident_byte  = {IDENT_HIGH, IDENT_LOW_NIB};

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign wr_fire       = (aw_held || s_axi_awvalid) && (w_held || s_axi_wvalid)
	                     && !s_axi_bvalid;

	// Write channel capture and response
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = s_axi_bvalid;
		next_bresp   = s_axi_bresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			unique case (next_aw_addr)
				ADDR_RESULT, ADDR_IDENT, ADDR_CONFIG, ADDR_STATUS,
				ADDR_IRQ_STAT, ADDR_IRQ_MASK, ADDR_RESULT_ST: next_bresp = RESP_OKAY;
				default: next_bresp = RESP_SLVERR;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
	end

	// Register file and conversion capture
	always_comb begin
		next_chsel         = chsel;
		next_common_mode   = common_mode;
		next_append_status = append_status;
		next_result        = result;
		next_not_ready     = not_ready;
		next_irq_mask      = irq_mask;
		irq_events         = '0;
		next_irq_stat      = irq_stat;
		if (rd_fire && (s_axi_araddr == ADDR_RESULT || s_axi_araddr == ADDR_RESULT_ST)) begin
			next_not_ready                = 1'b1;
			irq_events[IRQ_RESULT_READ]   = 1'b1;
		end
		if (conv_done) begin
			next_result.data           = conv_data;
			next_result.channel        = route.channel;
			next_not_ready             = 1'b0;
			irq_events[IRQ_RESULT_NEW] = 1'b1;
		end
		if (wr_fire) begin
			unique case (next_aw_addr)
				ADDR_CONFIG: begin
					if (next_w_strb[0]) begin
						next_chsel = next_w_data[CFG_CHSEL_LSB +: 8];
					end
					if (next_w_strb[1]) begin
						next_common_mode   = next_w_data[CFG_COMMON_BIT];
						next_append_status = next_w_data[CFG_APPEND_BIT];
					end
				end
				ADDR_IRQ_STAT: begin
					if (next_w_strb[0]) begin
						next_irq_stat = irq_stat & ~next_w_data[IRQ_WIDTH-1:0];
					end
				end
				ADDR_IRQ_MASK: begin
					if (next_w_strb[0]) begin
						next_irq_mask = next_w_data[IRQ_WIDTH-1:0];
					end
				end
				default: begin
				end
			endcase
		end
		// Set wins over clear
		next_irq_stat = next_irq_stat | irq_events;
	end

	// Read data path
	always_comb begin
		next_rvalid = s_axi_rvalid;
		next_rdata  = s_axi_rdata;
		next_rresp  = s_axi_rresp;
		if (rd_fire) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			unique case (s_axi_araddr)
				ADDR_RESULT: begin
					if (append_status) begin
						next_rdata = {result.data, status_byte};
					end else begin
						next_rdata = {8'h00, result.data};
					end
				end
				ADDR_RESULT_ST: next_rdata = {result.data, status_byte};
				ADDR_IDENT:     next_rdata = {24'h000000, ident_byte};
				ADDR_CONFIG:    next_rdata = {22'h0, append_status, common_mode, chsel};
				ADDR_STATUS:    next_rdata = {24'h000000, status_byte};
				ADDR_IRQ_STAT:  next_rdata = {30'h0, irq_stat};
				ADDR_IRQ_MASK:  next_rdata = {30'h0, irq_mask};
				default: begin
					next_rdata = 32'h00000000;
					next_rresp = RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h00000000;
			w_strb        <= 4'h0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= RESP_OKAY;
			chsel         <= CHSEL_RESET;
			common_mode   <= 1'b0;
			append_status <= 1'b0;
			result        <= {RESULT_RESET, 4'h0};
			not_ready     <= 1'b1;
			irq_stat      <= '0;
			irq_mask      <= '0;
		end else begin
			aw_held       <= next_aw_held;
			w_held        <= next_w_held;
			aw_addr       <= next_aw_addr;
			w_data        <= next_w_data;
			w_strb        <= next_w_strb;
			s_axi_bvalid  <= next_bvalid;
			s_axi_bresp   <= next_bresp;
			s_axi_rvalid  <= next_rvalid;
			s_axi_rdata   <= next_rdata;
			s_axi_rresp   <= next_rresp;
			chsel         <= next_chsel;
			common_mode   <= next_common_mode;
			append_status <= next_append_status;
			result        <= next_result;
			not_ready     <= next_not_ready;
			irq_stat      <= next_irq_stat;
			irq_mask      <= next_irq_mask;
		end
	end

	assign not_ready_n = !not_ready;
	assign irq         = |(irq_stat & irq_mask);

endmodule : adcsr_top
`default_nettype wire

// >>> verif/adcsr_asserts.sv
// Assertions on the ports of the channel-select block.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module adcsr_asserts
	import adcsr_pkg::*;
#(parameter logic [3:0] IDENT_HIGH = IDENT_HIGH_DEF)(
	// Clock, reset, modulator
	input wire logic         aclk,
	input wire logic         aresetn,
	input wire logic         conv_done,
	// Read channel
	input wire logic         s_axi_arvalid,
	input wire logic         s_axi_arready,
	input wire logic [7:0]   s_axi_araddr,
	input wire logic         s_axi_rvalid,
	input wire logic [31:0]  s_axi_rdata,
	input wire logic [1:0]   s_axi_rresp,
	// Write response and pins
	input wire logic         s_axi_bvalid,
	input wire adcsr_route_t route,
	input wire logic         not_ready_n
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_ar(logic [7:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	AST_POS_SEL: assert property (route.pos_sel == 16'h0001 << route.channel)
		else $error("positive select mismatch");
	AST_NEG_COM: assert property (route.neg_common |-> route.neg_sel == 16'h0000)
		else $error("negative select with common");
	AST_NEG_SEL: assert property (!route.neg_common |-> $onehot(route.neg_sel))
		else $error("negative select not one-hot");
	AST_ROUTE_WR: assert property ($changed(route) |-> $rose(s_axi_bvalid))
		else $error("routing changed without write");
	AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_IDENT: assert property (s_ar(ADDR_IDENT) |=> s_axi_rdata[7:0] == {IDENT_HIGH, IDENT_LOW_NIB})
		else $error("identification wrong");
	AST_RESULT_OK: assert property (s_ar(ADDR_RESULT) |=> s_axi_rresp == RESP_OKAY)
		else $error("result read refused");
	AST_NRDY: assert property ($rose(not_ready_n) |-> $past(conv_done))
		else $error("ready pin rose without a conversion");
	AST_NRDY_SET: assert property ($fell(not_ready_n) |-> $past(s_axi_arvalid && s_axi_arready))
		else $error("ready pin fell without a read");
endmodule : adcsr_asserts
`default_nettype wire

// >>> verif/adcsr_mod_model.sv
// Modulator stand-in: one conv_done pulse a set number of cycles after start.
// Assumes start is a one-cycle request on aclk.
`timescale 1ns/100ps
`default_nettype none
module adcsr_mod_model (
	// Request
	input  wire logic        aclk,
	input  wire logic        start,
	input  wire logic [23:0] value,
	input  wire logic [3:0]  delay,
	// Conversion
	output logic             conv_done,
	output logic [23:0]      conv_data
);
	logic [4:0]  cnt  = 5'h00;
	logic [23:0] held = 24'h000000;
	always @(posedge aclk) begin
		conv_done <= !start && cnt == 5'h01;
		if (start) begin
			cnt  <= {1'b0, delay} + 5'h01;
			held <= value;
		end else if (cnt != 5'h00)
			cnt <= cnt - 5'h01;
	end
	// Data is only valid beside the pulse
	assign conv_data = conv_done ? held : ~held;
endmodule : adcsr_mod_model
`default_nettype wire

// >>> verif/tb_top.sv
// Bench for the channel-select and result block.
// Drives AXI4-Lite and a modulator model on one 200 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top
	import adcsr_pkg::*;
;
	// Arbitrary identification nibble
	localparam logic [3:0] IDH = 4'ha;
	typedef struct packed {logic [9:0] cfg; logic [15:0] pos; logic [15:0] neg;} adcsr_row_t;
	logic aclk = 1'b0, aresetn = 1'b0, start = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
	logic [3:0] s_axi_wstrb = 4'hf, delay = 4'h1;
	logic [23:0] value = 24'h0, conv_data;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic conv_done, not_ready_n, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	adcsr_route_t route;
	int errors = 0, checks_done = 0;
	adcsr_row_t rows [6] = '{'{10'h000, 16'h0001, 16'h0001}, '{10'h0f0, 16'h8000, 16'h0001},
		'{10'h00f, 16'h0001, 16'h8000}, '{10'h05a, 16'h0020, 16'h0400},
		'{10'h1a5, 16'h0400, 16'h0000}, '{10'h1ff, 16'h8000, 16'h0000}};
	adcsr_top #(.IDENT_HIGH(IDH)) adcsr_top_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .conv_done, .conv_data, .route, .not_ready_n, .irq);
	adcsr_mod_model adcsr_mod_model_inst (.aclk, .start, .value, .delay, .conv_done, .conv_data);
	always #2.5 aclk = ~aclk;
	task stop_test;
		if (errors == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	// One write or read; waits for the answer under a bound
	task bus(input bit wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		bit aw, w;
		@(posedge aclk);
		aw = 1'b1;
		w = wr;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= wr;
		s_axi_wvalid <= wr;
		s_axi_bready <= wr;
		s_axi_arvalid <= !wr;
		s_axi_rready <= !wr;
		for (n = 0; n < 40; n++) begin
			@(posedge aclk);
			if (aw && (wr ? s_axi_awready : s_axi_arready)) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
				s_axi_arvalid <= 1'b0;
			end
			if (w && s_axi_wready) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
			if (wr ? s_axi_bvalid : s_axi_rvalid)
				break;
		end
		resp = wr ? s_axi_bresp : s_axi_rresp;
		rdat = s_axi_rdata;
		s_axi_bready <= 1'b0;
		s_axi_rready <= 1'b0;
		if (n == 40) begin
			errors++;
			stop_test();
		end
	endtask : bus
	task conv(input logic [23:0] v, input logic [3:0] dl);
		@(posedge aclk);
		value <= v;
		delay <= dl;
		start <= 1'b1;
		@(posedge aclk);
		start <= 1'b0;
		repeat (dl + 3) @(posedge aclk);
	endtask : conv
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		bus(0, ADDR_RESULT, 0);
		`CHK("reset result", 32'h0, rdat)
		`CHK("reset pos", 16'h0001, route.pos_sel)
		foreach (rows[i]) begin
			bus(1, ADDR_CONFIG, {22'h0, rows[i].cfg});
			`CHK("pos", rows[i].pos, route.pos_sel)
			`CHK("neg", rows[i].neg, route.neg_sel)
			`CHK("common", rows[i].cfg[8], route.neg_common)
			conv({rows[i].cfg[7:0], 16'h5a3c}, 4'(i));
			`CHK("pin ready", 1'b1, not_ready_n)
			`CHK("route chan", rows[i].cfg[7:4], route.channel)
			bus(0, ADDR_STATUS, 0);
			`CHK("chan", {1'b0, rows[i].cfg[7:4]}, {rdat[7], rdat[3:0]})
			bus(0, ADDR_RESULT, 0);
			`CHK("result", {8'h0, rows[i].cfg[7:0], 16'h5a3c}, rdat)
			`CHK("pin busy", 1'b0, not_ready_n)
			bus(0, ADDR_STATUS, 0);
			`CHK("not ready", 1'b1, rdat[7])
		end
		// Status appended so the host can tell the channel apart
		bus(1, ADDR_CONFIG, 32'h230);
		conv(24'habcdef, 4'h5);
		bus(0, ADDR_RESULT, 0);
		`CHK("append", {24'habcdef, 4'h3}, {rdat[31:8], rdat[3:0]})
		bus(1, ADDR_RESULT, 32'h123456);
		`CHK("ro bresp", RESP_OKAY, resp)
		bus(0, ADDR_RESULT, 0);
		`CHK("held", 24'habcdef, rdat[31:8])
		bus(1, ADDR_IDENT, 32'hff);
		bus(0, ADDR_IDENT, 0);
		`CHK("ident", {24'h0, IDH, IDENT_LOW_NIB}, rdat)
		bus(0, 8'h3c, 0);
		`CHK("unmapped", RESP_SLVERR, resp)
		bus(1, ADDR_IRQ_STAT, 32'h3);
		bus(1, ADDR_IRQ_MASK, 32'h0);
		conv(24'h000001, 4'h2);
		`CHK("masked", 1'b0, irq)
		bus(0, ADDR_IRQ_STAT, 0);
		`CHK("sticky", 2'h1, rdat[1:0])
		bus(1, ADDR_IRQ_MASK, 32'h1);
		@(posedge aclk);
		`CHK("irq on", 1'b1, irq)
		bus(1, ADDR_IRQ_STAT, 32'h1);
		@(posedge aclk);
		`CHK("irq clear", 1'b0, irq)
		// Reset in mid-run brings every register back
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		`CHK("rst pos", 16'h0001, route.pos_sel)
		`CHK("rst pin", 1'b0, not_ready_n)
		bus(0, ADDR_RESULT, 0);
		`CHK("rst result", 32'h0, rdat)
		bus(0, ADDR_CONFIG, 0);
		`CHK("rst cfg", 32'h0, rdat)
		bus(0, ADDR_IRQ_MASK, 0);
		`CHK("rst mask", 2'h0, rdat[1:0])
		stop_test();
	end
endmodule : tb_top
bind adcsr_top adcsr_asserts #(.IDENT_HIGH(IDENT_HIGH)) adcsr_asserts_inst (.aclk, .aresetn,
	.conv_done, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rdata,
	.s_axi_rresp, .s_axi_bvalid, .route, .not_ready_n);
`default_nettype wire
